// file: design/ring_counter_pkg.sv
// Constants shared by the complement ring down counter and its testbench.
// Assumes a single 10 MHz system clock; every pulse input is one clock wide.
package ring_counter_pkg;

    // ************************************************************
    // ring geometry
    // ************************************************************
    localparam int             RING_LEN        = 9;
    localparam int             POS_LSB         = 1;
    localparam int             POS_SERIAL_TAP  = 2;
    localparam int             POS_BORROW_IN   = 7;
    localparam int             POS_DELAY_INH   = 8;
    localparam int             POS_TOP         = 9;
    localparam int             PLAIN_SHIFT_TOP = 6;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [9:1]     RING_RESET      = 9'h1FF;
    localparam logic           SER_RESET       = 1'h1;
    localparam logic           STAGE_CLEAR     = 1'h0;

    // ************************************************************
    // burst and limits
    // ************************************************************
    localparam int             CNT_W           = 4;
    localparam logic [3:0]     LAST_SHIFT      = 4'h8;
    localparam int             COUNT_W         = 9;
    localparam int             RANGE_MAX_COUNT = 64;
    localparam int             AZIM_MAX_COUNT  = 256;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int             CLK_PERIOD_NS     = 100;
    localparam int             DRIVE_SPACING_NS  = 20000;
    localparam int             DRIVE_SPACING_CYC = DRIVE_SPACING_NS / CLK_PERIOD_NS;
    localparam int             GAP_LIMIT_CYC     = 2 * DRIVE_SPACING_CYC;
    localparam int             GAP_W             = 9;

    // ************************************************************
    // phases of a counting cycle
    // ************************************************************
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_COUNT,
        PH_BORROW,
        PH_CLEAR
    } phase_e;

endpackage : ring_counter_pkg

// file: design/two_entry_buffer.sv
// Two-entry valid/ready buffer; outputs come straight from flip-flops.
// Assumes one clock, asynchronous active-high reset and a clock enable.
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_rst,
    input  wire logic             i_clk_en,
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    logic             push;
    logic             pop;
    logic             head_valid_next;
    logic [WIDTH-1:0] head_data_next;
    logic             skid_valid_reg;
    logic             skid_valid_next;
    logic [WIDTH-1:0] skid_data_reg;
    logic [WIDTH-1:0] skid_data_next;

    assign push = i_clk_en & i_in_valid & o_in_ready;
    assign pop  = i_clk_en & o_out_valid & i_out_ready;

    // ************************************************************
    // next state: head word is the output, skid word catches a stall
    // ************************************************************
    always_comb begin
        head_valid_next = o_out_valid;
        head_data_next  = o_out_data;
        skid_valid_next = skid_valid_reg;
        skid_data_next  = skid_data_reg;
        if (!o_out_valid || pop) begin
            if (skid_valid_reg) begin
                head_valid_next = 1'b1;
                head_data_next  = skid_data_reg;
                skid_valid_next = push;
                skid_data_next  = i_in_data;
            end else begin
                head_valid_next = push;
                head_data_next  = i_in_data;
            end
        end else if (push) begin
            skid_valid_next = 1'b1;
            skid_data_next  = i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_out_valid    <= 1'b0;
            o_out_data     <= '0;
            skid_valid_reg <= 1'b0;
            skid_data_reg  <= '0;
            o_in_ready     <= 1'b1;
        end else if (i_clk_en) begin
            o_out_valid    <= head_valid_next;
            o_out_data     <= head_data_next;
            skid_valid_reg <= skid_valid_next;
            skid_data_reg  <= skid_data_next;
            o_in_ready     <= ~skid_valid_next;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    chk_full_refuses: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
        (skid_valid_reg && o_out_valid) |-> !o_in_ready)
        else $error("buffer accepts while both entries are held");

    chk_stall_holds: assert property (@(posedge i_sys_clk) disable iff (i_rst) // R8
        (o_out_valid && !i_out_ready) |=> (o_out_valid && $stable(o_out_data)))
        else $error("head word changed while stalled");

endmodule : two_entry_buffer

// file: design/complement_ring_down_counter.sv
// Serial ones-complement down counter built as a nine-position ring with
// add-in, borrow and borrow delay stages and a serial output stage.
// Assumes increment, drive and clear pulses are one clock wide and synchronous;
// the drive source honours o_drive_ready and sends bursts of nine.
//
// Functional notes
// R1: three phases: count without borrow, count with borrow, clear.
// R2: after reset ring positions 1-9 and serial stage hold 1.
// R3: increment sets add-in stage; other stages unchanged until next drive.
// R4: drive moves every stage to its successor; position 1 feeds 9.
// R5: add-in 1 feeds borrow stage input and inhibits position 9.
// R6: position 1 out feeds position 9 and inhibits borrow stage.
// R7: input and inhibit together on a shift store 0.
// R8: serial stage loads position 2, passes old content downstream.
// R9: readout register takes one bit per drive pulse.
// R10: increment complete after ninth drive; ring holds ones-complement of count.
// R11: from reset, one increment and nine shifts give 111 111 110.
// R12: second increment and nine shifts give 111 111 101.
// R13: borrow stage 1 passes to delay stage, recirculates unless inhibited.
// R14: delay stage input and borrow recirculation share one readout.
// R15: delay stage 1 inhibits position 8 and writes 1 into 7.
// R16: delay stage 1 holds back the moving zero by one position.
// R17: single borrow: lettered stages all 0 after third drive.
// R18: bit weights valid at reset and after ninth shift; position 1 lsb.
// R19: drive pulses come in bursts of nine, 20 us apart.
// R20: clear pulse sets ring to 1 and clears the delay stage.
// R21: range use counts to 64, azimuth use to 256.
// R22: at most one increment between bursts, none within a burst.
// R23: all stages update together from values before the drive.
`timescale 1ns/1ps
module complement_ring_down_counter
    import ring_counter_pkg::*;
#(
    parameter int MAX_COUNT = ring_counter_pkg::RANGE_MAX_COUNT
) (
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_rst,
    input  wire logic                            i_clk_en,
    input  wire logic                            i_incr,
    input  wire logic                            i_drive,
    input  wire logic                            i_clear,
    input  wire logic                            i_ser_ready,
    output logic                                 o_drive_ready,
    output logic                                 o_ser_valid,
    output logic                                 o_ser_bit,
    output logic [9:1]                           o_ring,
    output logic [ring_counter_pkg::COUNT_W-1:0] o_count,
    output logic                                 o_done,
    output logic                                 o_at_limit,
    output ring_counter_pkg::phase_e             o_phase,
    output logic                                 o_gap_err
);
    import ring_counter_pkg::*;

    localparam logic [COUNT_W:0] LIMIT     = (COUNT_W+1)'(MAX_COUNT);
    localparam logic [GAP_W-1:0] GAP_LIMIT = GAP_W'(GAP_LIMIT_CYC);

    // ************************************************************
    // state
    // ************************************************************
    logic [9:1]           ring_reg;
    logic [9:1]           ring_next;
    logic                 add_reg;
    logic                 add_next;
    logic                 borrow_reg;
    logic                 borrow_next;
    logic                 delay_reg;
    logic                 delay_next;
    logic                 ser_reg;
    logic                 ser_next;
    logic [CNT_W-1:0]     shift_cnt_reg;
    logic [GAP_W-1:0]     gap_cnt_reg;
    logic [PLAIN_SHIFT_TOP:1] ring_shifted;
    logic                 clear_acc;
    logic                 shift_acc;
    logic                 incr_acc;
    logic                 last_shift;
    logic                 borrow_ready;
    logic [COUNT_W-1:0]   count_next;

    // ************************************************************
    // accepted pulses: clear wins, a drive needs buffer room
    // ************************************************************
    assign clear_acc  = i_clk_en & i_clear;
    assign shift_acc  = i_clk_en & i_drive & o_drive_ready & ~i_clear;
    assign incr_acc   = i_clk_en & i_incr & ~i_drive & ~i_clear;
    assign last_shift = shift_acc & (shift_cnt_reg == LAST_SHIFT);
    assign count_next = ~ring_next;

    // ************************************************************
    // plain ring positions 1 to 6 take their upper neighbour
    // ************************************************************
    genvar k;
    generate
        for (k = POS_LSB; k <= PLAIN_SHIFT_TOP; k++) begin : g_plain
            assign ring_shifted[k] = ring_reg[k+1]; // R4
        end
    endgenerate

    // ************************************************************
    // next values, all from the state before the drive
    // ************************************************************
    always_comb begin
        ring_next   = ring_reg;
        add_next    = add_reg;
        borrow_next = borrow_reg;
        delay_next  = delay_reg;
        ser_next    = ser_reg;
        if (clear_acc) begin
            ring_next   = RING_RESET; // R20
            add_next    = STAGE_CLEAR;
            borrow_next = STAGE_CLEAR;
            delay_next  = STAGE_CLEAR; // R20
            ser_next    = SER_RESET;
        end else if (shift_acc) begin
            ring_next[PLAIN_SHIFT_TOP:POS_LSB] = ring_shifted; // R23
            ring_next[POS_TOP]       = ring_reg[POS_LSB] & ~add_reg; // R5 R6 R7
            ring_next[POS_DELAY_INH] = ring_reg[POS_TOP] & ~delay_reg; // R15 R7
            ring_next[POS_BORROW_IN] = ring_reg[POS_DELAY_INH] | delay_reg; // R15 R16
            add_next    = STAGE_CLEAR; // R17
            borrow_next = (add_reg | borrow_reg) & ~ring_reg[POS_LSB]; // R5 R6 R13 R7
            delay_next  = borrow_reg; // R13 R14
            ser_next    = ring_reg[POS_SERIAL_TAP]; // R8
        end else if (incr_acc) begin
            add_next = 1'b1; // R3
        end
    end

    // ************************************************************
    // stage registers
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ring_reg   <= RING_RESET; // R2
            add_reg    <= STAGE_CLEAR;
            borrow_reg <= STAGE_CLEAR;
            delay_reg  <= STAGE_CLEAR;
            ser_reg    <= SER_RESET; // R2
        end else if (i_clk_en) begin
            ring_reg   <= ring_next; // R4 R23
            add_reg    <= add_next;
            borrow_reg <= borrow_next;
            delay_reg  <= delay_next;
            ser_reg    <= ser_next;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ring <= RING_RESET;
        end else if (i_clk_en) begin
            o_ring <= ring_next;
        end
    end

    // ************************************************************
    // burst position: nine shifts finish one increment
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_cnt_reg <= '0;
        end else if (i_clk_en) begin
            if (clear_acc || last_shift) begin
                shift_cnt_reg <= '0; // R10
            end else if (shift_acc) begin
                shift_cnt_reg <= shift_cnt_reg + 1'b1;
            end
        end
    end

    // ************************************************************
    // count result, weights valid only after reset, clear or the ninth shift
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_count    <= '0;
            o_done     <= 1'b0;
            o_at_limit <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= last_shift; // R10
            if (clear_acc) begin
                o_count    <= '0;
                o_at_limit <= 1'b0;
            end else if (last_shift) begin
                o_count    <= count_next; // R18 R11 R12
                o_at_limit <= ({1'b0, count_next} >= LIMIT); // R21
            end
        end
    end

    // ************************************************************
    // phase of the cycle
    // ************************************************************
    assign borrow_ready = borrow_next | delay_next;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_phase <= PH_IDLE;
        end else if (i_clk_en) begin
            case (o_phase)
                PH_IDLE, PH_COUNT, PH_BORROW: begin
                    if (clear_acc) begin
                        o_phase <= PH_CLEAR; // R1
                    end else if (shift_acc && borrow_ready) begin
                        o_phase <= PH_BORROW; // R1
                    end else if (last_shift) begin
                        o_phase <= PH_IDLE;
                    end else if (shift_acc || incr_acc) begin
                        o_phase <= PH_COUNT; // R1
                    end
                end
                PH_CLEAR: begin
                    if (!clear_acc) begin
                        o_phase <= PH_IDLE;
                    end
                end
                default: begin
                    o_phase <= PH_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // gap watch: a burst that stalls well past its pulse spacing
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            gap_cnt_reg <= '0;
            o_gap_err   <= 1'b0;
        end else if (i_clk_en) begin
            if (clear_acc) begin
                gap_cnt_reg <= '0;
                o_gap_err   <= 1'b0;
            end else if (shift_acc || shift_cnt_reg == '0) begin
                gap_cnt_reg <= '0;
            end else if (gap_cnt_reg == GAP_LIMIT) begin
                o_gap_err <= 1'b1; // R19
            end else begin
                gap_cnt_reg <= gap_cnt_reg + 1'b1;
            end
        end
    end

    // ************************************************************
    // serial output buffer
    // ************************************************************
    two_entry_buffer #(
        .WIDTH (1)
    ) u_ser_buf (
        .i_sys_clk   (i_sys_clk),
        .i_rst       (i_rst),
        .i_clk_en    (i_clk_en),
        .i_in_valid  (shift_acc), // R8 R9
        .i_in_data   (ser_reg),
        .o_in_ready  (o_drive_ready),
        .o_out_valid (o_ser_valid),
        .o_out_data  (o_ser_bit),
        .i_out_ready (i_ser_ready)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    chk_clear_ring: assert property ( // R20
        clear_acc |=> (ring_reg == RING_RESET && !delay_reg && ser_reg && !borrow_reg))
        else $error("clear did not restore the ring");

    chk_incr_loads: assert property ( // R3
        incr_acc |=> (add_reg && $stable(ring_reg) && $stable(borrow_reg) && $stable(delay_reg)))
        else $error("increment disturbed other stages");

    chk_ring_rotate: assert property ( // R4
        shift_acc |=> (ring_reg[6:1] == $past(ring_reg[7:2])))
        else $error("plain ring positions did not rotate");

    chk_top_inhibit: assert property ( // R5
        shift_acc |=> (ring_reg[9] == ($past(ring_reg[1]) && !$past(add_reg)) && !add_reg))
        else $error("position 9 ignored its inhibit");

    chk_borrow_stage: assert property ( // R13
        shift_acc |=> (borrow_reg == (($past(add_reg) || $past(borrow_reg)) && !$past(ring_reg[1]))))
        else $error("borrow stage wrong after shift");

    chk_delay_load: assert property ( // R14
        shift_acc |=> (delay_reg == $past(borrow_reg)))
        else $error("delay stage did not follow borrow stage");

    chk_delay_effect: assert property ( // R15
        (shift_acc && delay_reg) |=> (ring_reg[7] && !ring_reg[8]))
        else $error("delay stage did not hold back the zero");

    chk_serial_tap: assert property ( // R8
        shift_acc |=> (ser_reg == $past(ring_reg[2])))
        else $error("serial stage did not load position 2");

    chk_burst_done: assert property ( // R10
        last_shift |=> (o_done && o_count == ~ring_reg && shift_cnt_reg == '0))
        else $error("ninth shift did not finish the increment");

    chk_single_borrow: assert property ( // R17
        (shift_acc && shift_cnt_reg == 4'h2 && !borrow_reg)
        |=> (!add_reg && !borrow_reg && !delay_reg))
        else $error("lettered stages not clear after third shift");

    chk_pos8_inhibit: assert property ( // R7
        shift_acc |=> (ring_reg[8] == ($past(ring_reg[9]) && !$past(delay_reg))))
        else $error("position 8 ignored the delay inhibit");

    chk_pos7_borrow: assert property ( // R16
        shift_acc |=> (ring_reg[7] == ($past(ring_reg[8]) || $past(delay_reg))))
        else $error("position 7 missed the delayed borrow");

    chk_refused_drive: assert property ( // R8
        (i_clk_en && i_drive && !i_clear && !o_drive_ready) |=> $stable(ring_reg))
        else $error("refused drive moved the ring");

    chk_phase_clear: assert property ( // R1
        clear_acc |=> (o_phase == PH_CLEAR))
        else $error("clear phase not shown");

    chk_phase_borrow: assert property ( // R1
        (shift_acc && (add_reg || borrow_reg) && !ring_reg[1]) |=> (o_phase == PH_BORROW))
        else $error("borrow phase not shown");

    chk_done_width: assert property ( // R10
        o_done |=> !o_done)
        else $error("done pulse longer than one cycle");

    chk_count_hold: assert property ( // R18
        (!last_shift && !clear_acc) |=> $stable(o_count))
        else $error("count changed inside a burst");

    chk_limit_flag: assert property ( // R21
        last_shift |=> (o_at_limit == ({1'b0, o_count} >= LIMIT)))
        else $error("limit flag disagrees with count");

    chk_gap_sticky: assert property ( // R19
        (o_gap_err && !clear_acc) |=> o_gap_err)
        else $error("gap flag dropped without clear");

endmodule : complement_ring_down_counter

// file: testbench/readout_register_model.sv
// Model of the downstream readout register fed by the serial output stage.
// Assumes a valid/ready handshake on the system clock; i_stall holds ready low.
`timescale 1ns/1ps
module readout_register_model (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    input  wire logic i_stall,
    input  wire logic i_valid,
    input  wire logic i_bit,
    output logic      o_ready
);
    // ************************************************************
    // first stage capture
    // ************************************************************
    logic got_q[$];

    assign o_ready = !i_stall;

    // one bit per taken drive enters the first stage
    always @(posedge i_sys_clk) begin
        if (!i_rst && i_valid && o_ready) begin
            got_q.push_back(i_bit);
        end
    end
endmodule : readout_register_model

// file: testbench/complement_ring_down_counter_tb.sv
// Self-checking bench for the complement ring down counter.
// Assumes the design package is compiled first; the readout model is the far side.
`timescale 1ns/1ps
module complement_ring_down_counter_tb;
    import ring_counter_pkg::*;
    // ************************************************************
    // signals and reference state
    // ************************************************************
    logic         i_sys_clk = 1'h0;
    logic         i_rst     = 1'h1;
    logic         i_clk_en  = 1'h1;
    logic         i_incr    = 1'h0;
    logic         i_drive   = 1'h0;
    logic         i_clear   = 1'h0;
    logic         i_stall   = 1'h0;
    logic         i_ser_ready;
    logic         o_drive_ready;
    logic         o_ser_valid;
    logic         o_ser_bit;
    logic [9:1]   o_ring;
    logic [8:0]   o_count;
    logic         o_done;
    logic         o_at_limit;
    phase_e       o_phase;
    logic         o_gap_err;
    int           bad_count = 0;
    int           n_tests   = 0;
    int           cnt;
    logic [9:1]   m_ring;
    logic         m_a;
    logic         m_b;
    logic         m_c;
    logic         m_s;
    logic         exp_q[$];

    always #50 i_sys_clk = ~i_sys_clk;

    complement_ring_down_counter #(.MAX_COUNT(RANGE_MAX_COUNT)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(i_clk_en), .i_incr(i_incr),
        .i_drive(i_drive), .i_clear(i_clear), .i_ser_ready(i_ser_ready),
        .o_drive_ready(o_drive_ready), .o_ser_valid(o_ser_valid), .o_ser_bit(o_ser_bit),
        .o_ring(o_ring), .o_count(o_count), .o_done(o_done), .o_at_limit(o_at_limit),
        .o_phase(o_phase), .o_gap_err(o_gap_err)
    );

    readout_register_model u_model (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stall(i_stall),
        .i_valid(o_ser_valid), .i_bit(o_ser_bit), .o_ready(i_ser_ready)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic model_reset();
        m_ring = RING_RESET;
        m_a    = 1'h0;
        m_b    = 1'h0;
        m_c    = 1'h0;
        m_s    = SER_RESET;
        cnt    = 0;
    endtask : model_reset

    // all next values come from the state before the shift
    task automatic model_shift();
        logic [9:1] r;
        r = m_ring;
        exp_q.push_back(m_s);
        m_s         = r[2];
        m_ring[9]   = r[1] & ~m_a;
        m_ring[8]   = r[9] & ~m_c;
        m_ring[7]   = r[8] | m_c;
        m_ring[6:1] = r[7:2];
        m_c         = m_b;
        m_b         = (m_a | m_b) & ~r[1];
        m_a         = 1'h0;
    endtask : model_shift

    task automatic drive_once();
        int k;
        k = 0;
        @(negedge i_sys_clk);
        while (o_drive_ready !== 1'h1) begin
            k++;
            if (k > 50) begin
                check("drive ready wait", 10'h1, {9'h0, o_drive_ready});
                close_out();
            end
            @(negedge i_sys_clk);
        end
        i_drive = 1'h1;
        model_shift();
        @(negedge i_sys_clk);
        i_drive = 1'h0;
        check("ring after shift", {1'h0, m_ring}, {1'h0, o_ring});
    endtask : drive_once

    task automatic incr_once();
        @(negedge i_sys_clk);
        i_incr = 1'h1;
        m_a    = 1'h1;
        @(negedge i_sys_clk);
        i_incr = 1'h0;
        check("ring after increment", {1'h0, m_ring}, {1'h0, o_ring});
        check("phase after increment", {8'h0, PH_COUNT}, {8'h0, o_phase});
    endtask : incr_once

    task automatic end_burst();
        cnt++;
        check("done pulse", 10'h1, {9'h0, o_done});
        check("count", 10'(cnt), {1'h0, o_count});
        check("ring complement", {1'h0, ~9'(cnt)}, {1'h0, o_ring});
        @(negedge i_sys_clk);
        check("done width", 10'h0, {9'h0, o_done});
        check("limit flag", {9'h0, cnt >= RANGE_MAX_COUNT}, {9'h0, o_at_limit});
    endtask : end_burst

    task automatic burst();
        incr_once();
        repeat (9) drive_once();
        end_burst();
    endtask : burst

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_reset();
        check("reset ring", {1'h0, RING_RESET}, {1'h0, o_ring});
        check("reset count", 10'h0, {1'h0, o_count});
        check("reset limit", 10'h0, {9'h0, o_at_limit});
    endtask : t_reset

    // second count stalls the readout so the buffer fills and refuses a drive
    task automatic t_stall_borrow();
        i_stall = 1'h1;
        incr_once();
        drive_once();
        drive_once();
        check("phase in borrow", {8'h0, PH_BORROW}, {8'h0, o_phase});
        repeat (2) @(negedge i_sys_clk);
        check("drive ready full", 10'h0, {9'h0, o_drive_ready});
        i_drive = 1'h1;
        @(negedge i_sys_clk);
        i_drive = 1'h0;
        check("ring after refused drive", {1'h0, m_ring}, {1'h0, o_ring});
        i_clk_en = 1'h0;
        i_clear  = 1'h1;
        @(negedge i_sys_clk);
        i_clear  = 1'h0;
        i_clk_en = 1'h1;
        check("ring while frozen", {1'h0, m_ring}, {1'h0, o_ring});
        check("phase while frozen", {8'h0, PH_BORROW}, {8'h0, o_phase});
        i_stall = 1'h0;
        repeat (7) drive_once();
        end_burst();
    endtask : t_stall_borrow

    // abandoned burst, then clear; a fresh count must not see a false borrow
    task automatic t_gap_clear();
        incr_once();
        drive_once();
        repeat (405) @(negedge i_sys_clk);
        check("gap flag", 10'h1, {9'h0, o_gap_err});
        i_clear = 1'h1;
        @(negedge i_sys_clk);
        i_clear = 1'h0;
        model_reset();
        check("ring after clear", {1'h0, RING_RESET}, {1'h0, o_ring});
        check("gap after clear", 10'h0, {9'h0, o_gap_err});
        check("phase after clear", {8'h0, PH_CLEAR}, {8'h0, o_phase});
        check("limit after clear", 10'h0, {9'h0, o_at_limit});
        burst();
    endtask : t_gap_clear

    task automatic t_serial();
        repeat (10) @(negedge i_sys_clk);
        check("serial bit count", 10'(exp_q.size()), 10'(u_model.got_q.size()));
        for (int i = 0; i < exp_q.size() && i < u_model.got_q.size(); i++) begin
            check("serial bit", {9'h0, exp_q[i]}, {9'h0, u_model.got_q[i]});
        end
    endtask : t_serial

    initial begin
        model_reset();
        repeat (3) @(negedge i_sys_clk);
        i_rst = 1'h0;
        t_reset();
        burst();
        t_stall_borrow();
        while (cnt < RANGE_MAX_COUNT) begin
            burst();
        end
        t_gap_clear();
        t_serial();
        close_out();
    end
endmodule : complement_ring_down_counter_tb
